// file: span_echo_pkg.sv
// Constants, register map and state types of the span and echo logic.
// Assumes one 125 MHz clock and a plain address/strobe register port.
package span_echo_pkg;

	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYC_DFLT = CLK_HZ / MS_PER_S;

	// Response figures in milliseconds.
	localparam int T_FAST_1M_MS = 15;
	localparam int T_FAST_2M_MS = 20;
	localparam int T_STD_1M_MS = 25;
	localparam int T_STD_2M_MS = 35;
	localparam int STD_SAMPLES = 2;

	// Loss of echo and teach timing in milliseconds.
	localparam int LOSS_SHORT_MS = 1000;
	localparam int LOSS_LONG_MS = 4000;
	localparam int TEACH_ENTER_MS = 3000;
	localparam int FAIL_FLASH_MS = 2000;
	localparam int FLASH_FAST_MS = 50;
	localparam int FLASH_SLOW_MS = 250;

	// ----------------------------------------------------------------
	// Data widths and end codes
	// ----------------------------------------------------------------
	localparam int DW = 16;
	localparam int CW = 12;
	localparam logic [CW-1:0] CODE_MIN = 12'h000;
	localparam logic [CW-1:0] CODE_MAX = 12'hfff;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_LIMITS = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_DIST = 8'h0c;

	localparam int CFG_FUNC_LSB = 0;
	localparam int CFG_RESP_LSB = 2;
	localparam int CFG_LOSS_LSB = 5;
	localparam int CFG_MODEL_LSB = 7;
	localparam int CFG_SLOPE_BIT = 9;
	localparam int CFG_W = 10;
	localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;

	localparam int ST_STATE_LSB = 12;
	localparam int ST_PRESENT_BIT = 15;

	// Field encodings.
	localparam logic [1:0] FUNC_ANY = 2'h0;
	localparam logic [1:0] FUNC_OBJECT = 2'h1;
	localparam logic [1:0] FUNC_NEAR_ONLY = 2'h2;
	localparam logic [1:0] FUNC_WINDOW = 2'h3;
	localparam logic [2:0] RESP_STD = 3'h0;
	localparam logic [2:0] RESP_FAST = 3'h1;
	localparam logic [2:0] RESP_SHIFT_OFS = 3'h1;
	localparam logic [1:0] LOSS_HOLD_FIRST = 2'h2;
	localparam logic [1:0] MODEL_1M = 2'h0;
	localparam logic [1:0] MODEL_8M = 2'h2;

	// Teach sequence states.
	typedef enum logic [2:0] {
		T_RUN, T_ENTER, T_ENTERED, T_WAIT, T_PRESS, T_FAIL
	} teach_t;

endpackage

// file: span_echo_logic.sv
// Echo gating, output averaging, limit teaching and loss-of-echo control.
// Assumes echo_valid/echo_dist come from the time-of-flight logic on ref_clk,
// the teach button is a raw pin, and the limit store answers on the same clock.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module span_echo_logic
	import span_echo_pkg::*;
#(
	parameter int MS_CYC = MS_CYC_DFLT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic echo_valid,
	input wire logic [DW-1:0] echo_dist,
	output logic ping_req,
	input wire logic teach_btn_n,
	input wire logic [DW-1:0] nv_lim_a_in,
	input wire logic [DW-1:0] nv_lim_b_in,
	output logic nv_wr,
	output logic [DW-1:0] nv_lim_a,
	output logic [DW-1:0] nv_lim_b,
	output logic [CW-1:0] out_code,
	output logic led_red,
	output logic led_green,
	output logic led_level
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [CFG_W-1:0] cfg;
		logic [31:0] rdata;
		logic b1;
		logic b2;
		logic loaded;
		logic [DW-1:0] lim_a;
		logic [DW-1:0] lim_b;
		logic [DW-1:0] tmp;
		logic [31:0] ms_cnt;
		logic tick;
		logic [11:0] ping_cnt;
		logic ping;
		logic wait_echo;
		logic first_pend;
		logic [DW-1:0] pos_dist;
		logic [DW-1:0] acc_dist;
		logic [DW-1:0] filt;
		logic [DW-1:0] prev;
		logic got;
		logic present;
		logic [12:0] loss_cnt;
		teach_t tstate;
		logic idx;
		logic [11:0] tcnt;
		logic [7:0] fast_cnt;
		logic [7:0] slow_cnt;
		logic flash_fast;
		logic flash_slow;
		logic [CW-1:0] code;
		logic led_r;
		logic led_g;
		logic [CW-1:0] pwm;
		logic led_lvl;
		logic nv_wr;
	} state_t;

	localparam state_t RESET_STATE = '{cfg: CFG_RESET, tstate: T_RUN, default: '0};
	localparam logic [31:0] MS_LAST = 32'(MS_CYC - 1);

	state_t r_reg;
	state_t r_next;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Linear code between the limits, clamped at the two end codes.
	function automatic logic [CW-1:0] span_code(input logic [DW-1:0] d,
		input logic [DW-1:0] lo, input logic [DW-1:0] hi);
		logic [DW+CW-1:0] q;
		q = '0;
		if (d <= lo) begin
			return CODE_MIN;
		end else if (d >= hi) begin
			return CODE_MAX;
		end
		q = {d - lo, {CW{1'b0}}} / (DW+CW)'(hi - lo);
		return q[CW-1:0];
	endfunction

	// One step of the exponential filter with gain two to the minus k.
	function automatic logic [DW-1:0] exp_step(input logic [DW-1:0] y,
		input logic [DW-1:0] x, input logic [2:0] k);
		logic signed [DW:0] diff;
		logic signed [DW:0] sum;
		diff = $signed({1'b0, x}) - $signed({1'b0, y});
		sum = $signed({1'b0, y}) + (diff >>> k);
		return sum[DW-1:0];
	endfunction

	// Gate test of one echo for the selected functionality.
	function automatic logic echo_ok(input logic [1:0] f, input logic [DW-1:0] d,
		input logic [DW-1:0] lo, input logic [DW-1:0] hi);
		case (f)
			FUNC_ANY: echo_ok = 1'b1;
			FUNC_WINDOW: echo_ok = (d >= lo) && (d <= hi);
			default: echo_ok = (d >= lo);
		endcase
	endfunction

	// Configuration fields and sorted limits.
	logic [1:0] func;
	logic [2:0] resp;
	logic [1:0] loss_sel;
	logic [1:0] model;
	logic slope_fall;
	logic [DW-1:0] near_lim;
	logic [DW-1:0] far_lim;
	logic btn;
	logic accept;
	logic [11:0] ping_ms;
	logic [12:0] loss_ms;
	logic [DW:0] mean_sum;

	assign func = r_reg.cfg[CFG_FUNC_LSB +: 2];
	assign resp = r_reg.cfg[CFG_RESP_LSB +: 3];
	assign loss_sel = r_reg.cfg[CFG_LOSS_LSB +: 2];
	assign model = r_reg.cfg[CFG_MODEL_LSB +: 2];
	assign slope_fall = r_reg.cfg[CFG_SLOPE_BIT];
	assign near_lim = (r_reg.lim_a <= r_reg.lim_b) ? r_reg.lim_a : r_reg.lim_b;
	assign far_lim = (r_reg.lim_a <= r_reg.lim_b) ? r_reg.lim_b : r_reg.lim_a;
	assign btn = r_reg.b2;
	assign mean_sum = {1'b0, echo_dist} + {1'b0, r_reg.prev};

	// A ping stays open until an echo is taken; modes other than 01 close on the first.
	assign accept = echo_valid && r_reg.wait_echo
		&& echo_ok(func, echo_dist, near_lim, far_lim);

	// Ping period: standard spreads two pings over its response, others ping at fast rate.
	always_comb begin
		if (model == MODEL_1M) begin
			ping_ms = (resp == RESP_STD) ? 12'(T_STD_1M_MS / STD_SAMPLES) : 12'(T_FAST_1M_MS);
		end else begin
			ping_ms = (resp == RESP_STD) ? 12'(T_STD_2M_MS / STD_SAMPLES)
				: 12'(T_FAST_2M_MS);
		end
		loss_ms = (model == MODEL_8M) ? 13'(LOSS_LONG_MS) : 13'(LOSS_SHORT_MS);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// All behaviour is computed here from the registered copy.
	always_comb begin
		r_next = r_reg;
		r_next.tick = 1'b0;
		r_next.ping = 1'b0;
		r_next.nv_wr = 1'b0;
		r_next.rdata = '0;

		// Two-stage synchroniser for the low-active button pin.
		r_next.b1 = ~teach_btn_n;
		r_next.b2 = r_reg.b1;

		// Limits come back from storage in the first cycle after reset.
		if (!r_reg.loaded) begin
			r_next.loaded = 1'b1;
			r_next.lim_a = nv_lim_a_in;
			r_next.lim_b = nv_lim_b_in;
		end

		// Register port: one writable configuration word, three status words.
		if (wr && addr == ADDR_CONFIG) begin
			r_next.cfg = wdata[CFG_W-1:0];
		end
		if (rd) begin
			case (addr)
				ADDR_CONFIG: r_next.rdata = 32'(r_reg.cfg);
				ADDR_LIMITS: r_next.rdata = {far_lim, near_lim};
				ADDR_STATUS: r_next.rdata = 32'({r_reg.present, r_reg.tstate, r_reg.code});
				ADDR_DIST: r_next.rdata = 32'(r_reg.acc_dist);
				default: r_next.rdata = '0;
			endcase
		end

		// Millisecond tick and the two flash rates.
		if (r_reg.ms_cnt == MS_LAST) begin
			r_next.ms_cnt = '0;
			r_next.tick = 1'b1;
		end else begin
			r_next.ms_cnt = r_reg.ms_cnt + 32'h1;
		end
		if (r_reg.tick) begin
			r_next.fast_cnt = r_reg.fast_cnt + 8'h1;
			r_next.slow_cnt = r_reg.slow_cnt + 8'h1;
			if (r_reg.fast_cnt == 8'(FLASH_FAST_MS - 1)) begin
				r_next.fast_cnt = '0;
				r_next.flash_fast = ~r_reg.flash_fast;
			end
			if (r_reg.slow_cnt == 8'(FLASH_SLOW_MS - 1)) begin
				r_next.slow_cnt = '0;
				r_next.flash_slow = ~r_reg.flash_slow;
			end
		end

		// Ping request opens a new echo window.
		if (r_reg.tick) begin
			if (r_reg.ping_cnt >= ping_ms - 12'h1) begin
				r_next.ping_cnt = '0;
				r_next.ping = 1'b1;
				r_next.wait_echo = 1'b1;
				r_next.first_pend = 1'b1;
			end else begin
				r_next.ping_cnt = r_reg.ping_cnt + 12'h1;
			end
		end

		// Echo handling; an echo in the timeout cycle wins over the loss.
		if (echo_valid) begin
			r_next.present = 1'b1;
			r_next.loss_cnt = '0;
			if (r_reg.first_pend) begin
				r_next.first_pend = 1'b0;
				r_next.pos_dist = echo_dist;
			end
			if (accept) begin
				r_next.wait_echo = 1'b0;
				r_next.got = 1'b1;
				r_next.acc_dist = echo_dist;
				r_next.prev = echo_dist;
				if (!r_reg.got || resp == RESP_FAST) begin
					r_next.filt = echo_dist;
				end else if (resp == RESP_STD) begin
					r_next.filt = mean_sum[DW:1];
				end else begin
					r_next.filt = exp_step(r_reg.filt, echo_dist, resp - RESP_SHIFT_OFS);
				end
			end else if (func != FUNC_OBJECT) begin
				r_next.wait_echo = 1'b0;
			end
		end else if (r_reg.tick) begin
			if (r_reg.loss_cnt >= loss_ms - 13'h1) begin
				r_next.present = 1'b0;
				if (loss_sel < LOSS_HOLD_FIRST) begin
					r_next.got = 1'b0;
				end
			end else begin
				r_next.loss_cnt = r_reg.loss_cnt + 13'h1;
			end
		end

		// Teach sequence; only the entry hold (T_ENTER) and the fail flash have a time limit.
		case (r_reg.tstate)
			T_RUN: begin
				if (btn) begin
					r_next.tstate = T_ENTER;
					r_next.tcnt = '0;
				end
			end
			T_ENTER: begin
				if (!btn) begin
					r_next.tstate = T_RUN;
				end else if (r_reg.tick) begin
					if (r_reg.tcnt == 12'(TEACH_ENTER_MS - 1)) begin
						r_next.tstate = T_ENTERED;
						r_next.idx = 1'b0; // A new session always asks for the first limit in green.
					end else begin
						r_next.tcnt = r_reg.tcnt + 12'h1;
					end
				end
			end
			T_ENTERED: begin
				if (!btn) begin
					r_next.tstate = T_WAIT;
					r_next.idx = 1'b0;
				end
			end
			T_WAIT: begin
				if (btn) begin
					r_next.tstate = T_PRESS;
				end
			end
			T_PRESS: begin
				if (!btn) begin
					if (!r_reg.present) begin
						r_next.tstate = T_FAIL;
						r_next.tcnt = '0;
					end else if (!r_reg.idx) begin
						r_next.tmp = r_reg.pos_dist;
						r_next.idx = 1'b1;
						r_next.tstate = T_WAIT;
					end else begin
						r_next.lim_a = r_reg.tmp;
						r_next.lim_b = r_reg.pos_dist;
						r_next.nv_wr = 1'b1;
						r_next.tstate = T_RUN;
					end
				end
			end
			T_FAIL: begin
				if (r_reg.tick) begin
					if (r_reg.tcnt == 12'(FAIL_FLASH_MS - 1)) begin
						r_next.tstate = T_WAIT;
					end else begin
						r_next.tcnt = r_reg.tcnt + 12'h1;
					end
				end
			end
			default: r_next.tstate = T_RUN;
		endcase

		// Output code: forced end value until an echo is held, else the mapped distance.
		if (!r_reg.got) begin
			r_next.code = loss_sel[0] ? CODE_MAX : CODE_MIN;
		end else if (slope_fall) begin
			r_next.code = ~span_code(r_reg.filt, near_lim, far_lim);
		end else begin
			r_next.code = span_code(r_reg.filt, near_lim, far_lim);
		end

		// Multicolour LED: red and green together give amber.
		case (r_reg.tstate)
			T_ENTER: begin
				r_next.led_r = r_reg.flash_fast;
				r_next.led_g = r_reg.flash_fast;
			end
			T_ENTERED, T_WAIT: begin
				r_next.led_r = r_reg.idx && r_reg.flash_slow;
				r_next.led_g = r_reg.flash_slow;
			end
			T_PRESS: begin
				r_next.led_r = 1'b1;
				r_next.led_g = r_reg.present;
			end
			T_FAIL: begin
				r_next.led_r = r_reg.flash_slow;
				r_next.led_g = 1'b0;
			end
			default: begin
				r_next.led_r = r_reg.present && (r_reg.pos_dist < near_lim
					|| r_reg.pos_dist > far_lim);
				r_next.led_g = r_reg.present && r_reg.pos_dist >= near_lim;
			end
		endcase

		// Level LED: pulse width follows the output code.
		r_next.pwm = r_reg.pwm + 12'h1;
		r_next.led_lvl = (r_reg.code > r_reg.pwm) || (r_reg.code == CODE_MAX);
	end

	// State register with synchronous reset.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_reg <= RESET_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register.
	assign rdata = r_reg.rdata;
	assign ping_req = r_reg.ping;
	assign nv_wr = r_reg.nv_wr;
	assign nv_lim_a = r_reg.lim_a;
	assign nv_lim_b = r_reg.lim_b;
	assign out_code = r_reg.code;
	assign led_red = r_reg.led_r;
	assign led_green = r_reg.led_g;
	assign led_level = r_reg.led_lvl;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_limits_sorted: assert property (
		rd && addr == ADDR_LIMITS |=> rdata[31:16] >= rdata[15:0])
		else $error("near limit above far limit");
	a_window_discard: assert property (
		echo_valid && r_reg.wait_echo && func == FUNC_WINDOW && echo_dist > far_lim
		|=> $stable(r_reg.filt) && !r_reg.wait_echo)
		else $error("echo beyond window changed the output");
	a_fast_direct: assert property (
		accept && resp == RESP_FAST |=> r_reg.filt == $past(echo_dist))
		else $error("fast response did not follow the echo");
	a_std_mean: assert property (
		accept && r_reg.got && resp == RESP_STD
		|=> r_reg.filt == DW'(({1'b0, $past(echo_dist)} + {1'b0, $past(r_reg.prev)}) >> 1))
		else $error("standard response is not the mean of two");
	a_object_keeps: assert property (
		echo_valid && r_reg.wait_echo && func == FUNC_OBJECT && echo_dist < near_lim
		|=> r_reg.wait_echo)
		else $error("object mode closed the ping on a near echo");
	a_forced_min: assert property (
		!r_reg.got && !loss_sel[0] ##1 !r_reg.got |-> out_code == CODE_MIN)
		else $error("output not at minimum without echo");
	a_teach_wait: assert property (
		r_reg.tstate == T_WAIT && !btn |=> r_reg.tstate == T_WAIT)
		else $error("teach wait left without a press");
	a_teach_store: assert property (
		r_reg.tstate == T_PRESS && !btn && r_reg.present && r_reg.idx
		|=> nv_wr && r_reg.tstate == T_RUN ##1 !nv_wr)
		else $error("second limit not written to storage");
	a_fail_red: assert property (
		r_reg.tstate == T_FAIL ##1 r_reg.tstate == T_FAIL |-> !led_green)
		else $error("green shown during failed teach flash");
	a_press_colour: assert property (
		r_reg.tstate == T_PRESS ##1 r_reg.tstate == T_PRESS
		|-> led_red && led_green == $past(r_reg.present))
		else $error("wrong colour while teach button held");

	c_accept: cover property (accept);
	c_teach_done: cover property (r_reg.nv_wr);
	c_fail: cover property (r_reg.tstate == T_FAIL);
	c_loss: cover property ($fell(r_reg.got));

endmodule // span_echo_logic

`default_nettype wire

// file: echo_front_model.sv
// Model of the echo receiver and the limit store that face the span logic.
// Assumes pings are one-cycle pulses on ref_clk and the store is written on nv_wr.
`timescale 1ns/10ps
`default_nettype none

module echo_front_model
	import span_echo_pkg::*;
#(
	parameter logic [DW-1:0] NV_A = 16'h044c,
	parameter logic [DW-1:0] NV_B = 16'h0064
) (
	input wire logic ref_clk,
	input wire logic ping_req,
	input wire logic echo_on,
	input wire logic [DW-1:0] dist_1,
	input wire logic [DW-1:0] dist_2,
	output logic echo_valid,
	output logic [DW-1:0] echo_dist,
	input wire logic nv_wr,
	input wire logic [DW-1:0] nv_lim_a,
	input wire logic [DW-1:0] nv_lim_b,
	output logic [DW-1:0] nv_lim_a_in,
	output logic [DW-1:0] nv_lim_b_in
);
	// ----------------------------------------------------------------
	// Echo return
	// ----------------------------------------------------------------
	logic [3:0] flight_reg;

	// Start values, so that nothing is unknown at time zero.
	initial begin
		flight_reg = 4'h0;
		echo_valid = 1'b0;
		echo_dist = 16'h0000;
		nv_lim_a_in = NV_A;
		nv_lim_b_in = NV_B;
	end

	// A ping returns dist_1, then dist_2 one cycle later when nonzero.
	// Outside echoes the distance toggles, so a stale value is never usable.
	always @(posedge ref_clk) begin
		echo_valid <= 1'b0;
		echo_dist <= ~echo_dist;
		if (ping_req && echo_on) begin
			flight_reg <= 4'h9;
		end else if (flight_reg != 4'h0) begin
			flight_reg <= flight_reg - 4'h1;
		end
		if (flight_reg == 4'h2) begin
			echo_valid <= 1'b1;
			echo_dist <= dist_1;
		end
		if (flight_reg == 4'h1 && dist_2 != 16'h0000) begin
			echo_valid <= 1'b1;
			echo_dist <= dist_2;
		end
	end

	// ----------------------------------------------------------------
	// Nonvolatile limit store
	// ----------------------------------------------------------------
	// The store keeps both limits from one write pulse across resets.
	always @(posedge ref_clk) begin
		if (nv_wr === 1'b1) begin
			nv_lim_a_in <= nv_lim_a;
			nv_lim_b_in <= nv_lim_b;
		end
	end
endmodule // echo_front_model

`default_nettype wire

// file: ultrasonic_span_echo_logic_tb_top.sv
// Self-checking bench: registers, echo gating, response, echo loss and teaching.
// Assumes the package and the echo model are compiled before this file.
`timescale 1ns/10ps
`default_nettype none

module ultrasonic_span_echo_logic_tb_top
	import span_echo_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic teach_btn_n = 1'b1;
	logic echo_on = 1'b1;
	logic [DW-1:0] dist_1 = 16'h0258;
	logic [DW-1:0] dist_2 = 16'h0000;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic echo_valid, ping_req, nv_wr, led_red, led_green, led_level;
	logic [DW-1:0] echo_dist, nv_lim_a, nv_lim_b, nv_a_in, nv_b_in;
	logic [CW-1:0] out_code;
	int errors = 0;
	int check_count = 0;
	int nv_pulses = 0;
	int near_mm = 100;
	int far_mm = 1100;
	int gap = 0;
	localparam int TB_MS = 10;

	span_echo_logic #(.MS_CYC(TB_MS)) u_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .echo_valid(echo_valid),
		.echo_dist(echo_dist), .ping_req(ping_req), .teach_btn_n(teach_btn_n),
		.nv_lim_a_in(nv_a_in), .nv_lim_b_in(nv_b_in), .nv_wr(nv_wr), .nv_lim_a(nv_lim_a),
		.nv_lim_b(nv_lim_b), .out_code(out_code), .led_red(led_red),
		.led_green(led_green), .led_level(led_level));

	echo_front_model u_front (.ref_clk(ref_clk), .ping_req(ping_req), .echo_on(echo_on),
		.dist_1(dist_1), .dist_2(dist_2), .echo_valid(echo_valid), .echo_dist(echo_dist),
		.nv_wr(nv_wr), .nv_lim_a(nv_lim_a), .nv_lim_b(nv_lim_b), .nv_lim_a_in(nv_a_in),
		.nv_lim_b_in(nv_b_in));

	// ----------------------------------------------------------------
	// Clock, store-write counter and helpers
	// ----------------------------------------------------------------
	// The 125 MHz clock.
	always #4 ref_clk = ~ref_clk;

	// Counts store-write pulses.
	always @(posedge ref_clk) begin
		if (nv_wr === 1'b1) begin
			nv_pulses++;
		end
	end

	// Expected output code for a distance against the current limits.
	function automatic logic [31:0] code_of(input int d);
		if (d <= near_mm) return 32'h0;
		if (d >= far_mm) return 32'hfff;
		return 32'((d - near_mm) * 4096 / (far_mm - near_mm));
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe edge.
	task automatic rd_reg(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		rv = rdata;
	endtask

	task automatic cfg(input int f, input int r, input int l, input int s);
		wr_reg(ADDR_CONFIG, 32'(f | (r << CFG_RESP_LSB) | (l << CFG_LOSS_LSB) | (s << CFG_SLOPE_BIT)));
	endtask

	task automatic setd(input int a, input int b, input logic on);
		@(posedge ref_clk);
		dist_1 <= 16'(a);
		dist_2 <= 16'(b);
		echo_on <= on;
	endtask

	task automatic btn(input logic v);
		@(posedge ref_clk);
		teach_btn_n <= v;
	endtask

	// Waits for n pings, each with its echoes and the output update after them.
	task automatic pings(input int n);
		for (int i = 0; i < n; i++) begin
			for (int w = 0; w < 400; w++) begin
				@(posedge ref_clk);
				#1;
				if (ping_req === 1'b1) break;
			end
			repeat (14) @(posedge ref_clk);
			#1;
		end
	endtask

	task automatic state_is(input teach_t s);
		rd_reg(ADDR_STATUS);
		check(32'(rv[14:12]), 32'(s));
	endtask

	// Counts the cycles from one ping request to the next.
	task automatic ping_gap(output int n);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
		end while (ping_req !== 1'b1);
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (ping_req !== 1'b1 && n < 1000);
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Cuts a hang short well after the expected run of about 78500 cycles.
	initial begin
		repeat (100000) @(posedge ref_clk);
		errors++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		check(32'(out_code), 32'h0);
		rd_reg(ADDR_LIMITS);
		check(rv, 32'h044c_0064);
		rd_reg(8'h10);
		check(rv, 32'h0);
		cfg(0, 1, 0, 0);
		pings(2);
		check(32'(out_code), code_of(600));
		check(32'({led_red, led_green}), 32'h1);
		rd_reg(ADDR_DIST);
		check(rv, 32'h0258);
		ping_gap(gap);
		check(32'(gap), 32'(T_FAST_1M_MS * TB_MS));
		cfg(0, 1, 0, 1);
		pings(1);
		check(32'(out_code), 32'hfff - code_of(600));
		// A near echo followed by an in-span one, under every functionality setting.
		for (int f = 0; f < 4; f++) begin
			cfg(f, 1, 0, 0);
			setd(300, 0, 1'b1);
			pings(2);
			setd(50, 600, 1'b1);
			pings(2);
			check(32'(out_code), f == 0 ? 32'h0 : (f == 1 ? code_of(600) : code_of(300)));
			if (f == 0) check(32'({led_red, led_green, led_level}), 32'h4);
		end
		setd(1500, 0, 1'b1);
		pings(2);
		check(32'(out_code), code_of(300));
		setd(700, 0, 1'b1);
		pings(2);
		check(32'(out_code), code_of(700));
		cfg(0, 1, 0, 0);
		setd(1500, 0, 1'b1);
		pings(2);
		check(32'({led_red, led_green, led_level}), 32'h7);
		check(32'(out_code), 32'hfff);
		cfg(0, 0, 0, 0);
		setd(600, 0, 1'b1);
		pings(3);
		setd(800, 0, 1'b1);
		pings(1);
		check(32'(out_code), code_of(700));
		pings(1);
		check(32'(out_code), code_of(800));
		cfg(0, 2, 0, 0);
		setd(600, 0, 1'b1);
		pings(1);
		check(32'(out_code > code_of(600) && out_code < code_of(800)), 32'h1);
		check(32'(out_code), code_of(700));
		// Two-metre model: ping spacing for the fast and the standard response.
		wr_reg(ADDR_CONFIG, 32'((1 << CFG_RESP_LSB) | (1 << CFG_MODEL_LSB)));
		ping_gap(gap);
		check(32'(gap), 32'(T_FAST_2M_MS * TB_MS));
		wr_reg(ADDR_CONFIG, 32'(1 << CFG_MODEL_LSB));
		ping_gap(gap);
		check(32'(gap), 32'(T_STD_2M_MS / STD_SAMPLES * TB_MS));
		// Echo loss: forced to maximum under selection 1, held under selection 3.
		cfg(0, 1, 1, 0);
		pings(2);
		setd(600, 0, 1'b0);
		repeat (9800) @(posedge ref_clk);
		#1;
		check(32'(out_code), code_of(600));
		repeat (400) @(posedge ref_clk);
		#1;
		check(32'(out_code), 32'hfff);
		check(32'({led_red, led_green}), 32'h0);
		cfg(0, 1, 3, 0);
		setd(600, 0, 1'b1);
		pings(2);
		setd(600, 0, 1'b0);
		repeat (10400) @(posedge ref_clk);
		#1;
		check(32'(out_code), code_of(600));
		// Teaching, first with no target in sight, then with targets at 300 and 900.
		btn(1'b0);
		repeat (29900) @(posedge ref_clk);
		state_is(T_ENTER);
		repeat (200) @(posedge ref_clk);
		state_is(T_ENTERED);
		btn(1'b1);
		repeat (20) @(posedge ref_clk);
		btn(1'b0);
		repeat (20) @(posedge ref_clk);
		#1;
		check(32'({led_red, led_green}), 32'h2);
		btn(1'b1);
		repeat (20) @(posedge ref_clk);
		state_is(T_FAIL);
		repeat (20100) @(posedge ref_clk);
		state_is(T_WAIT);
		check(32'(nv_pulses), 32'h0);
		setd(300, 0, 1'b1);
		pings(2);
		btn(1'b0);
		pings(2);
		check(32'({led_red, led_green}), 32'h3);
		btn(1'b1);
		repeat (20) @(posedge ref_clk);
		state_is(T_WAIT);
		setd(900, 0, 1'b1);
		pings(2);
		btn(1'b0);
		pings(2);
		btn(1'b1);
		repeat (20) @(posedge ref_clk);
		state_is(T_RUN);
		check(32'(nv_pulses), 32'h1);
		check({nv_lim_a, nv_lim_b}, 32'h012c_0384);
		near_mm = 300;
		far_mm = 900;
		setd(600, 0, 1'b1);
		pings(2);
		check(32'(out_code), code_of(600));
		// A second reset must bring the taught limits back from the store.
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		check(32'(out_code), 32'h0);
		rd_reg(ADDR_LIMITS);
		check(rv, 32'h0384_012c);
		end_of_test();
	end
endmodule // ultrasonic_span_echo_logic_tb_top

`default_nettype wire
